// file: src/dmr_pkg.sv
package dmr_pkg;

    // ---------------------------------------------------------------
    // Mode-register addresses
    // ---------------------------------------------------------------
    localparam logic [5:0] MA_OSC_RUN_TIME = 6'h17;
    localparam logic [5:0] MA_REFRESH_GUARD = 6'h18;
    localparam logic [5:0] MA_REPAIR_RESOURCE = 6'h19;
    localparam logic [5:0] MA_RESERVED_LO = 6'h1a;
    localparam logic [5:0] MA_RESERVED_HI = 6'h1d;
    localparam logic [5:0] MA_IGNORED_TEST = 6'h1e;

    // ---------------------------------------------------------------
    // Multi-purpose command operands
    // ---------------------------------------------------------------
    localparam logic [6:0] MPC_OSC_STOP = 7'h4d;
    localparam logic [6:0] MPC_OSC_START = 7'h4b;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int GUARD_ENABLE_BIT = 7;
    localparam int GUARD_BANK_MSB = 6;
    localparam int GUARD_BANK_LSB = 4;
    localparam int UNLIMITED_BIT = 3;
    localparam int RUN_MODE_MSB = 7;
    localparam int RUN_MODE_LSB = 6;
    localparam int RUN_CODE_MSB = 5;

    // ---------------------------------------------------------------
    // Reset and fixed read values
    // ---------------------------------------------------------------
    localparam logic [7:0] RUN_TIME_RESET = 8'h00;
    localparam logic GUARD_ENABLE_RESET = 1'b0;
    localparam logic [2:0] GUARD_BANK_RESET = 3'h0;
    localparam logic UNLIMITED_ACTIVATE = 1'b1;
    localparam logic [2:0] MAX_ACTIVATE_COUNT = 3'h0;
    localparam logic [7:0] RESERVED_READ = 8'h00;

    // ---------------------------------------------------------------
    // Oscillator stop counts in link clocks
    // ---------------------------------------------------------------
    localparam int OSC_CNT_W = 14;
    localparam logic [3:0] RUN_CODE_SHIFT_PAD = 4'h0;
    localparam logic [13:0] OSC_STOP_MODE1 = 14'h0800;
    localparam logic [13:0] OSC_STOP_MODE2 = 14'h1000;
    localparam logic [13:0] OSC_STOP_MODE3 = 14'h2000;
    localparam logic [1:0] RUN_MODE_CODE = 2'h0;
    localparam logic [1:0] RUN_MODE_2K = 2'h1;
    localparam logic [1:0] RUN_MODE_4K = 2'h2;

    // ---------------------------------------------------------------
    // Command bundle sampled on the link clock
    // ---------------------------------------------------------------
    typedef struct packed {
        logic mrw;
        logic mrr;
        logic mpc;
        logic [5:0] addr;
        logic [7:0] op;
    } dmr_cmd_t;

endpackage : dmr_pkg

// file: src/dmr_sync.sv
`timescale 1ns/1ps
module dmr_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            stage1 <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : dmr_sync

// file: src/dmr_mode_regs.sv
`timescale 1ns/1ps
// Functional notes
// - Decode addresses 17h, 18h, 19h, 1Eh.
// - Codes 1-63 stop oscillator after code*16.
// - Modes 01/10 stop after 2048/4096 clocks.
// - Zero code runs until stop command.
// - Write-only guard enable and bank select.
// - Bit 3 chooses count or unlimited.
// - Report zero count, no activate limit.
// - Unlimited means no activation limit applies.
// - One repair-available bit per bank.
// - Test register writes are ignored.
// - Write and read registers by address.
// - Start command clears the oscillator count.
module dmr_mode_regs #(
    parameter logic [13:0] STOP_CLKS_MODE3 = dmr_pkg::OSC_STOP_MODE3,
    parameter int BANKS = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Link from the controller
    input wire logic link_ck,
    input wire dmr_pkg::dmr_cmd_t link_cmd,
    // Repair fuse status per bank
    input wire logic [BANKS-1:0] repair_resource_available,
    // Read answer
    output logic [7:0] rd_data,
    output logic rd_valid,
    // Row-hammer guard controls
    output logic hammer_guard_enable,
    output logic [2:0] hammer_guard_bank,
    // Oscillator
    output logic osc_running,
    output logic [15:0] osc_count
);

    // ---------------------------------------------------------------
    // Input synchronisation and link edge detection
    // ---------------------------------------------------------------
    logic s_ck;
    dmr_pkg::dmr_cmd_t s_cmd;
    logic [BANKS-1:0] s_repair;
    logic ck_prev;
    logic [7:0] run_time;
    logic [13:0] osc_elapsed;

    dmr_sync #(.WIDTH(1 + $bits(dmr_pkg::dmr_cmd_t) + BANKS)) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in({link_ck, link_cmd, repair_resource_available}),
        .sync_out({s_ck, s_cmd, s_repair})
    );

    wire ck_rise = s_ck & ~ck_prev;
    wire wr_take = ck_rise & s_cmd.mrw;
    wire rd_take = ck_rise & s_cmd.mrr;
    wire mpc_take = ck_rise & s_cmd.mpc;

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    wire hit_run = s_cmd.addr == dmr_pkg::MA_OSC_RUN_TIME;
    wire hit_guard = s_cmd.addr == dmr_pkg::MA_REFRESH_GUARD;
    wire hit_repair = s_cmd.addr == dmr_pkg::MA_REPAIR_RESOURCE;
    wire hit_test = s_cmd.addr == dmr_pkg::MA_IGNORED_TEST;
    wire hit_rsv = s_cmd.addr >= dmr_pkg::MA_RESERVED_LO && s_cmd.addr <= dmr_pkg::MA_RESERVED_HI;

    // ---------------------------------------------------------------
    // Read multiplexer
    // ---------------------------------------------------------------
    wire [7:0] guard_read = {4'h0, dmr_pkg::UNLIMITED_ACTIVATE, dmr_pkg::MAX_ACTIVATE_COUNT};
    wire [7:0] repair_read = 8'(s_repair);
    logic [7:0] next_rd_data;
    always_comb
    begin
        if (hit_guard)
            next_rd_data = guard_read;
        else if (hit_repair)
            next_rd_data = repair_read;
        else
            next_rd_data = dmr_pkg::RESERVED_READ;
    end

    // ---------------------------------------------------------------
    // Oscillator stop limit
    // ---------------------------------------------------------------
    wire [1:0] run_mode = run_time[dmr_pkg::RUN_MODE_MSB:dmr_pkg::RUN_MODE_LSB];
    wire auto_stop = run_time != 8'h00;
    logic [13:0] stop_limit;
    always_comb
    begin
        case (run_mode)
            dmr_pkg::RUN_MODE_CODE: stop_limit = {4'h0, run_time[dmr_pkg::RUN_CODE_MSB:0],
                                                   dmr_pkg::RUN_CODE_SHIFT_PAD};
            dmr_pkg::RUN_MODE_2K: stop_limit = dmr_pkg::OSC_STOP_MODE1;
            dmr_pkg::RUN_MODE_4K: stop_limit = dmr_pkg::OSC_STOP_MODE2;
            default: stop_limit = STOP_CLKS_MODE3;
        endcase
    end

    wire osc_start = mpc_take && s_cmd.op[6:0] == dmr_pkg::MPC_OSC_START;
    wire osc_stop_cmd = mpc_take && s_cmd.op[6:0] == dmr_pkg::MPC_OSC_STOP && !auto_stop;
    wire osc_tick = osc_running && ck_rise;
    wire [13:0] next_elapsed = osc_elapsed + 14'h0001;
    wire osc_done = osc_tick && auto_stop && next_elapsed == stop_limit;
    wire [15:0] next_count = (osc_count == 16'hffff) ? osc_count : osc_count + 16'h0001;

    // ---------------------------------------------------------------
    // Register writes and read answer
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ck_prev <= 1'b0;
            run_time <= dmr_pkg::RUN_TIME_RESET;
            hammer_guard_enable <= dmr_pkg::GUARD_ENABLE_RESET;
            hammer_guard_bank <= dmr_pkg::GUARD_BANK_RESET;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end
        else
        begin
            ck_prev <= s_ck;
            rd_valid <= rd_take;
            if (rd_take)
                rd_data <= next_rd_data;
            if (wr_take && hit_run)
                run_time <= s_cmd.op;
            if (wr_take && hit_guard)
            begin
                hammer_guard_enable <= s_cmd.op[dmr_pkg::GUARD_ENABLE_BIT];
                hammer_guard_bank <= s_cmd.op[dmr_pkg::GUARD_BANK_MSB:dmr_pkg::GUARD_BANK_LSB];
            end
        end
    end

    // ---------------------------------------------------------------
    // Oscillator timer
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            osc_running <= 1'b0;
            osc_elapsed <= 14'h0000;
            osc_count <= 16'h0000;
        end
        else if (osc_start)
        begin
            osc_running <= 1'b1;
            osc_elapsed <= 14'h0000;
            osc_count <= 16'h0000;
        end
        else if (osc_stop_cmd || osc_done)
        begin
            osc_running <= 1'b0;
            osc_count <= osc_tick ? next_count : osc_count;
        end
        else if (osc_tick)
        begin
            osc_elapsed <= next_elapsed;
            osc_count <= next_count;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_read_answer_cause: assert property (rd_valid |-> $past(rd_take))
        else $error("read answer without a read command");
    a_guard_write_fields: assert property (wr_take && hit_guard |=>
        hammer_guard_enable == $past(s_cmd.op[7]) && hammer_guard_bank == $past(s_cmd.op[6:4]))
        else $error("guard fields not written");
    a_activate_report: assert property (rd_take && hit_guard |=> rd_data == 8'h08)
        else $error("activate report wrong");
    a_repair_bits: assert property (rd_take && hit_repair |=> rd_data == $past(repair_read))
        else $error("repair flags wrong");
    a_test_ignored: assert property (wr_take && (hit_test || hit_rsv) |=>
        $stable(run_time) && $stable(hammer_guard_enable) && $stable(hammer_guard_bank))
        else $error("ignored write changed state");
    a_reserved_zero: assert property (rd_take && hit_rsv |=> rd_data == 8'h00)
        else $error("reserved read not zero");
    a_start_clears: assert property (osc_start |=> osc_running && osc_count == 16'h0000)
        else $error("start did not clear count");
    a_auto_stop_time: assert property (osc_done && !osc_start |=>
        !osc_running && osc_elapsed == $past(stop_limit) - 14'h0001)
        else $error("automatic stop at wrong count");
    a_manual_stop: assert property (osc_stop_cmd && !osc_start |=> !osc_running)
        else $error("stop command ignored");
    a_code_limit: assert property (run_mode == 2'h0 |-> stop_limit == 14'(run_time[5:0]) * 14'h0010)
        else $error("code limit wrong");
    a_mode_2k_limit: assert property (run_mode == 2'h1 |-> stop_limit == 14'h0800)
        else $error("2048 clock limit wrong");
    a_mode_4k_limit: assert property (run_mode == 2'h2 |-> stop_limit == 14'h1000)
        else $error("4096 clock limit wrong");
    a_guard_hold: assert property (!(wr_take && hit_guard) |=>
        $stable(hammer_guard_enable) && $stable(hammer_guard_bank))
        else $error("guard fields changed without a write");
    a_idle_count_hold: assert property (!osc_running && !osc_start |=> $stable(osc_count))
        else $error("count moved while stopped");
    a_valid_pulse: assert property (rd_valid |=> !rd_valid)
        else $error("read answer longer than one clock");
    a_tick_count: assert property (osc_tick && !osc_start && osc_count != 16'hffff |=>
        osc_count == $past(osc_count) + 16'h0001)
        else $error("count did not follow a link edge");

    // ---------------------------------------------------------------
    // Cover points
    // ---------------------------------------------------------------
    c_auto_stop: cover property (osc_done);
    c_restart: cover property (osc_start && osc_running);
    c_manual_stop: cover property (osc_stop_cmd && osc_running);
    c_guard_write: cover property (wr_take && hit_guard && s_cmd.op[7]);
    c_repair_read: cover property (rd_take && hit_repair);

endmodule : dmr_mode_regs

// file: verification/dmr_ctrl_model.sv
`timescale 1ns/1ps
module dmr_ctrl_model (
    // Clock
    input wire logic clk,
    // Link to the device
    output logic link_ck,
    output dmr_pkg::dmr_cmd_t link_cmd
);

    // ---------------------------------------------------------------
    // Command issue
    // ---------------------------------------------------------------
    initial
    begin
        link_ck = 1'b0;
        link_cmd = '0;
    end

    // Sends one command per 400 ns link clock, entered and left at a falling clk edge.
    // Every address, the ignored test register included, gets the same timing.
    task automatic send(input logic mrw, input logic mrr, input logic mpc, input logic [5:0] addr,
                        input logic [7:0] op);
        begin
            link_cmd = {mrw, mrr, mpc, addr, op};
            repeat (4) @(negedge clk);
            link_ck = 1'b1;
            repeat (3) @(negedge clk);
            // Once the hold time runs out the fields show the inverse, with no command flag.
            link_cmd = {3'b000, ~addr, ~op};
            @(negedge clk);
            link_ck = 1'b0;
        end
    endtask : send

endmodule : dmr_ctrl_model

// file: verification/tb_dram_mode_regs_osc_trr_ppr.sv
`timescale 1ns/1ps
module tb_dram_mode_regs_osc_trr_ppr;

    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic clk;
    logic reset;
    logic link_ck;
    dmr_pkg::dmr_cmd_t link_cmd;
    logic [7:0] repair_resource_available;
    logic [7:0] rd_data;
    logic rd_valid;
    logic hammer_guard_enable;
    logic [2:0] hammer_guard_bank;
    logic osc_running;
    logic [15:0] osc_count;
    int mismatches = 0;
    int check_count = 0;
    logic [7:0] exp_q[$];
    logic [7:0] guard_op;
    logic [7:0] run_op[5] = '{8'h02, 8'h3f, 8'h40, 8'h80, 8'hc0};
    logic [15:0] run_lim[5] = '{16'h0020, 16'h03f0, 16'h0800, 16'h1000, 16'h0028};
    logic [5:0] rd_addr[9] = '{6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h3f};

    dmr_ctrl_model i_ctrl (.clk(clk), .link_ck(link_ck), .link_cmd(link_cmd));

    dmr_mode_regs #(.STOP_CLKS_MODE3(14'd40), .BANKS(8)) i_dut (
        .clk(clk), .reset(reset), .link_ck(link_ck), .link_cmd(link_cmd),
        .repair_resource_available(repair_resource_available), .rd_data(rd_data), .rd_valid(rd_valid),
        .hammer_guard_enable(hammer_guard_enable), .hammer_guard_bank(hammer_guard_bank),
        .osc_running(osc_running), .osc_count(osc_count)
    );

    // ---------------------------------------------------------------
    // Checking and reporting
    // ---------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want)
        begin
            mismatches++;
            $display("Error at %0t ns: saw %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    task automatic rd(input logic [5:0] addr, input logic [7:0] want);
        exp_q.push_back(want);
        i_ctrl.send(1'b0, 1'b1, 1'b0, addr, 8'h00);
    endtask : rd

    task automatic wr(input logic [5:0] addr, input logic [7:0] op);
        i_ctrl.send(1'b1, 1'b0, 1'b0, addr, op);
    endtask : wr

    task automatic mpc(input logic [6:0] op);
        i_ctrl.send(1'b0, 1'b0, 1'b1, 6'($urandom), {1'b0, op});
    endtask : mpc

    task automatic idle(input int n);
        repeat (n) i_ctrl.send(1'b0, 1'b0, 1'b0, 6'($urandom), 8'($urandom));
    endtask : idle

    // Each read answer is compared with the oldest expected value, or with dead when no value is queued.
    always @(negedge clk)
    begin
        if (rd_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                check({8'h00, rd_data}, 16'hdead);
            else
                check({8'h00, rd_data}, {8'h00, exp_q.pop_front()});
        end
    end

    // ---------------------------------------------------------------
    // Clock, watchdog and stimulus
    // ---------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial
    begin
        #4500000;
        mismatches++;
        give_verdict();
    end

    initial
    begin
        reset = 1'b1;
        repair_resource_available = 8'h00;
        void'($urandom(32'h1d2b));
        repeat (6) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        check({15'h0000, hammer_guard_enable}, 16'h0000);
        check({15'h0000, osc_running}, 16'h0000);
        repair_resource_available = 8'($urandom);
        for (int i = 0; i < 9; i++)
        begin
            if (rd_addr[i] == 6'h18)
                rd(rd_addr[i], 8'h08);
            else if (rd_addr[i] == 6'h19)
                rd(rd_addr[i], repair_resource_available);
            else
                rd(rd_addr[i], 8'h00);
        end
        for (int i = 0; i < 3; i++)
        begin
            guard_op = 8'($urandom) | (i == 0 ? 8'h80 : 8'h00);
            wr(dmr_pkg::MA_REFRESH_GUARD, guard_op);
            check({15'h0000, hammer_guard_enable}, {15'h0000, guard_op[7]});
            check({13'h0000, hammer_guard_bank}, {13'h0000, guard_op[6:4]});
            wr(dmr_pkg::MA_IGNORED_TEST, ~guard_op);
            wr(6'h1a + 6'(i), ~guard_op);
            wr(dmr_pkg::MA_REPAIR_RESOURCE, ~guard_op);
            check({12'h000, hammer_guard_enable, hammer_guard_bank}, {12'h000, guard_op[7:4]});
            rd(dmr_pkg::MA_REFRESH_GUARD, 8'h08);
        end
        for (int m = 0; m < 5; m++)
        begin
            wr(dmr_pkg::MA_OSC_RUN_TIME, run_op[m][7:6] == 2'b00 ? run_op[m] : {run_op[m][7:6], 6'($urandom)});
            mpc(dmr_pkg::MPC_OSC_START);
            check({15'h0000, osc_running}, 16'h0001);
            idle(int'(run_lim[m]) - 1);
            check({15'h0000, osc_running}, 16'h0001);
            idle(1);
            check({15'h0000, osc_running}, 16'h0000);
            check(osc_count, run_lim[m]);
        end
        // Manual stop mode: the stop operand is only sent while the run-time field is zero.
        wr(dmr_pkg::MA_OSC_RUN_TIME, 8'h00);
        mpc(dmr_pkg::MPC_OSC_START);
        check(osc_count, 16'h0000);
        idle(5);
        check(osc_count, 16'h0005);
        mpc(dmr_pkg::MPC_OSC_STOP);
        idle(3);
        check({15'h0000, osc_running}, 16'h0000);
        mpc(dmr_pkg::MPC_OSC_START);
        check({15'h0000, osc_running}, 16'h0001);
        check(osc_count, 16'h0000);
        repeat (4) @(negedge clk);
        check(16'(exp_q.size()), 16'h0000);
        give_verdict();
    end

endmodule : tb_dram_mode_regs_osc_trr_ppr
